// [common/serial_port_defines.vh]
// shared constants for the serial register port and its bus slave
`ifndef SERIAL_PORT_DEFINES_VH
`define SERIAL_PORT_DEFINES_VH
`define OFS_CTRL 12'h200
`define OFS_STATUS 12'h204
`define OFS_MASK 12'h208
`define OFS_INFO 12'h20C
`define LOCK_PAGE 8'h21
`define REG_PAGE 3'h0
`define CTRL_FAULT_EN 0
`define ST_FAULT 0
`define ST_WDONE 1
`define ST_RDONE 2
`define ST_W 3
`define MODE_REG_ADDR 7'h01
`define MODE_MSB 2
`define LEGAL_MODES 8'h1E
`define CNT_16 6'h10
`define CNT_24 6'h18
`define CNT_32 6'h20
`define CNT_MAX 6'h3F
`define CNT_BYTE0 6'h07
`define CNT_BYTE1 6'h0F
`define CNT_BYTE2 6'h17
`define CNT_BYTE3 6'h1F
`define FIRST_BYTE 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// [rtl/sync_2ff.v]
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module sync_2ff #(
	parameter W = 3,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input wire aclk, // system clock
	input wire aresetn, // synchronous reset, active low
	input wire [W-1:0] d, // asynchronous inputs
	output wire [W-1:0] q // synchronised outputs
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1)
		begin : bit_sync
			always @(posedge aclk)
			begin
				if (!aresetn)
				begin
					meta_q[g] <= INIT[g];
					sync_q[g] <= INIT[g];
				end
				else
				begin
					meta_q[g] <= d[g];
					sync_q[g] <= meta_q[g];
				end
			end
		end
	endgenerate
	assign q = sync_q;
endmodule

// [rtl/host_serial_register_port.v]
// serial register port with 128 byte registers and an axi4-lite slave
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "serial_port_defines.vh"
module host_serial_register_port (
	input wire aclk, // system clock
	input wire aresetn, // synchronous reset, active low
	input wire awvalid, // write address valid
	output wire awready, // write address ready
	input wire [11:0] awaddr, // write byte address
	input wire wvalid, // write data valid
	output wire wready, // write data ready
	input wire [31:0] wdata, // write data
	input wire [3:0] wstrb, // write byte strobes
	output wire bvalid, // write response valid
	input wire bready, // write response ready
	output wire [1:0] bresp, // write response
	input wire arvalid, // read address valid
	output wire arready, // read address ready
	input wire [11:0] araddr, // read byte address
	output wire rvalid, // read data valid
	input wire rready, // read data ready
	output wire [31:0] rdata, // read data
	output wire [1:0] rresp, // read response
	input wire serial_clk, // serial clock from host
	input wire chip_select_n, // transfer frame, active low
	input wire serial_in_pin, // serial data from host
	output wire serial_out_pin, // serial data to host
	output wire serial_out_en, // high while driving the output
	output wire irq // level interrupt
);
	reg [7:0] regs_q [0:127];
	reg [127:0] lock_q;
	reg ctrl_q;
	reg [`ST_W-1:0] st_q;
	reg [`ST_W-1:0] st_d;
	reg [`ST_W-1:0] mask_q;
	reg irq_q;
	reg awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	reg aw_hold_q, w_hold_q;
	reg [11:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	reg [1:0] bresp_q, rresp_q;
	reg [31:0] rdata_q;
	wire [2:0] pins;
	reg sclk_q, cs_q;
	reg [5:0] cnt_q;
	reg [7:0] in_q;
	reg [7:0] in_d;
	reg [6:0] addr_q;
	reg ro_q;
	reg [7:0] out_q;
	reg [23:0] wdat_q;
	reg so_q, soe_q;
	reg [5:0] last_cnt_q;
	reg last_ro_q;
	reg [2:0] wr_ok;
	reg ev_lock, ev_mode;
	reg [7:0] wa;
	reg [7:0] wbyte;
	integer k;
	integer j;
	integer i;
	// legal operating-mode codes, one bit per code; a literal cannot be bit-selected
	localparam [7:0] legal_modes = `LEGAL_MODES;
	wire sclk_s = pins[0];
	wire cs_s = pins[1];
	wire sin_s = pins[2];
	wire sclk_fall = sclk_q & ~sclk_s & ~cs_s;
	wire sclk_rise = ~sclk_q & sclk_s & ~cs_s;
	wire cs_fall = cs_q & ~cs_s;
	wire cs_rise = ~cs_q & cs_s;
	wire cnt_ok = (cnt_q == `CNT_16) | (cnt_q == `CNT_24) | (cnt_q == `CNT_32);
	wire [2:0] nby = cnt_q[5:3] - 3'h1;
	wire do_wr = aw_hold_q & w_hold_q & ~bvalid_q;
	wire ar_go = arvalid & arready_q;
	wire ev_cnt = cs_rise & ~cnt_ok;

	// pin inputs cross into the aclk domain
	sync_2ff #(.W(3), .INIT(3'b010)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({serial_in_pin, chip_select_n, serial_clk}),
		.q(pins)
	);

	// register byte as seen on the serial output, zero beyond the map
	function [7:0] spi_rd;
		input [7:0] a;
		begin
			spi_rd = a[7] ? 8'h00 : regs_q[a[6:0]];
		end
	endfunction

	function mapped;
		input [11:0] a;
		begin
			mapped = (a[11:9] == `REG_PAGE) | (a[11:4] == `LOCK_PAGE) | (a == `OFS_CTRL) |
				(a == `OFS_STATUS) | (a == `OFS_MASK) | (a == `OFS_INFO);
		end
	endfunction

	function [31:0] axi_rd;
		input [11:0] a;
		begin
			axi_rd = 32'h0000_0000;
			if (a[11:9] == `REG_PAGE)
				axi_rd = {24'h00_0000, regs_q[a[8:2]]};
			else if (a[11:4] == `LOCK_PAGE)
				axi_rd = lock_q[{a[3:2], 5'h00} +: 32];
			else if (a == `OFS_CTRL)
				axi_rd = {31'h0000_0000, ctrl_q};
			else if (a == `OFS_STATUS)
				axi_rd = {29'h0000_0000, st_q};
			else if (a == `OFS_MASK)
				axi_rd = {29'h0000_0000, mask_q};
			else if (a == `OFS_INFO)
				axi_rd = {18'h0_0000, last_cnt_q, 6'h00, last_ro_q, ~cs_s};
		end
	endfunction

	// serial shift engine
	always @*
	begin
		in_d = {in_q[6:0], sin_s};
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
			cnt_q <= 6'h00;
			in_q <= 8'h00;
			addr_q <= 7'h00;
			ro_q <= 1'b0;
			out_q <= 8'h00;
			wdat_q <= 24'h00_0000;
			so_q <= 1'b0;
			soe_q <= 1'b0;
			last_cnt_q <= 6'h00;
			last_ro_q <= 1'b0;
		end
		else
		begin
			sclk_q <= sclk_s;
			cs_q <= cs_s;
			if (cs_fall)
			begin
				cnt_q <= 6'h00;
				out_q <= `FIRST_BYTE;
				so_q <= 1'b0;
				soe_q <= 1'b1;
				ro_q <= 1'b0;
			end
			else if (cs_rise)
			begin
				soe_q <= 1'b0;
				so_q <= 1'b0;
				last_cnt_q <= cnt_q;
				last_ro_q <= ro_q;
			end
			else if (sclk_fall)
			begin
				in_q <= in_d;
				if (cnt_q != `CNT_MAX)
					cnt_q <= cnt_q + 6'h01;
				case (cnt_q)
					`CNT_BYTE0:
					begin
						addr_q <= in_d[7:1];
						ro_q <= in_d[0];
						out_q <= spi_rd({1'b0, in_d[7:1]});
					end
					`CNT_BYTE1:
					begin
						wdat_q[7:0] <= in_d;
						out_q <= spi_rd({1'b0, addr_q} + 8'h01);
					end
					`CNT_BYTE2:
					begin
						wdat_q[15:8] <= in_d;
						out_q <= spi_rd({1'b0, addr_q} + 8'h02);
					end
					`CNT_BYTE3:
					begin
						wdat_q[23:16] <= in_d;
						out_q <= 8'h00;
					end
					default:
					begin
						out_q <= out_q;
					end
				endcase
			end
			else if (sclk_rise)
			begin
				if (ro_q && cnt_q >= `CNT_32)
					so_q <= in_q[0];
				else
					so_q <= out_q[7];
				out_q <= {out_q[6:0], 1'b0};
			end
		end
	end

	// commit check at the end of a frame
	always @*
	begin
		wr_ok = 3'b000;
		ev_lock = 1'b0;
		ev_mode = 1'b0;
		wa = 8'h00;
		wbyte = 8'h00;
		for (k = 0; k < 3; k = k + 1)
		begin
			wa = {1'b0, addr_q} + k[7:0];
			wbyte = wdat_q[8*k +: 8];
			// read-only frames and bad counts never reach the registers
			if (cs_rise && cnt_ok && !ro_q && k[2:0] < nby && !wa[7])
			begin
				if (lock_q[wa[6:0]])
					ev_lock = 1'b1;
				else if (wa[6:0] == `MODE_REG_ADDR && !legal_modes[wbyte[`MODE_MSB:0]])
					ev_mode = 1'b1;
				else
					wr_ok[k] = 1'b1;
			end
		end
	end

	// register file, shared by the serial port and the bus
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (i = 0; i < 128; i = i + 1)
				regs_q[i] <= 8'h00;
		end
		else
		begin
			if (do_wr && awaddr_q[11:9] == `REG_PAGE && wstrb_q[0])
				regs_q[awaddr_q[8:2]] <= wdata_q[7:0];
			for (i = 0; i < 3; i = i + 1)
			begin
				if (wr_ok[i])
					regs_q[addr_q + i[6:0]] <= wdat_q[8*i +: 8];
			end
		end
	end

	// sticky events, cleared by a status read; a new event wins
	always @*
	begin
		st_d = st_q;
		if (ar_go && araddr == `OFS_STATUS)
			st_d = {`ST_W{1'b0}};
		if (ctrl_q && (ev_cnt || ev_lock || ev_mode))
			st_d[`ST_FAULT] = 1'b1;
		if (|wr_ok)
			st_d[`ST_WDONE] = 1'b1;
		if (cs_rise && cnt_ok && ro_q)
			st_d[`ST_RDONE] = 1'b1;
	end

	// bus slave write channel
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OKAY;
			ctrl_q <= 1'b0;
			mask_q <= {`ST_W{1'b0}};
			lock_q <= 128'h0;
		end
		else
		begin
			if (awvalid && awready_q)
			begin
				aw_hold_q <= 1'b1;
				awready_q <= 1'b0;
				awaddr_q <= awaddr;
			end
			else if (!aw_hold_q && !bvalid_q)
				awready_q <= 1'b1;
			if (wvalid && wready_q)
			begin
				w_hold_q <= 1'b1;
				wready_q <= 1'b0;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			else if (!w_hold_q && !bvalid_q)
				wready_q <= 1'b1;
			if (do_wr)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
				if (awaddr_q == `OFS_CTRL && wstrb_q[0])
					ctrl_q <= wdata_q[`CTRL_FAULT_EN];
				if (awaddr_q == `OFS_MASK && wstrb_q[0])
					mask_q <= wdata_q[`ST_W-1:0];
				if (awaddr_q[11:4] == `LOCK_PAGE)
				begin
					for (j = 0; j < 4; j = j + 1)
					begin
						if (wstrb_q[j])
							lock_q[{awaddr_q[3:2], 5'h00} + j * 8 +: 8] <= wdata_q[8*j +: 8];
					end
				end
			end
			else if (bvalid_q && bready)
				bvalid_q <= 1'b0;
		end
	end

	// bus slave read channel and interrupt
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `RESP_OKAY;
			st_q <= {`ST_W{1'b0}};
			irq_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			irq_q <= |(st_d & mask_q);
			if (ar_go)
			begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= axi_rd(araddr);
				rresp_q <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (rvalid_q && rready)
				rvalid_q <= 1'b0;
			else if (!rvalid_q)
				arready_q <= 1'b1;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign serial_out_pin = so_q;
	assign serial_out_en = soe_q;
	assign irq = irq_q;
endmodule

// [tb/host_serial_register_port_checker.sv]
// assertions on the serial register port pins
`timescale 1ns/10ps
module port_checker (
	input logic aclk, // clock
	input logic aresetn, // reset
	input logic awvalid, // aw valid
	input logic awready, // aw ready
	input logic [11:0] awaddr, // aw addr
	input logic wvalid, // w valid
	input logic wready, // w ready
	input logic bvalid, // b valid
	input logic [1:0] bresp, // b resp
	input logic arvalid, // ar valid
	input logic arready, // ar ready
	input logic [11:0] araddr, // ar addr
	input logic rvalid, // r valid
	input logic [31:0] rdata, // r data
	input logic [1:0] rresp, // r resp
	input logic chip_select_n, // frame
	input logic serial_out_pin, // out data
	input logic serial_out_en // out enable
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_aw;
		awvalid && awready;
	endsequence
	sequence s_both;
		s_aw ##0 wvalid && wready;
	endsequence
	property p_wr_resp;
		s_both |-> ##2 bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_rd_ans;
		arvalid && arready |=> rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	property p_wr_bad;
		s_both ##0 awaddr >= 12'h220 |-> ##2 bvalid && bresp == 2'h2;
	endproperty
	a_wr_bad: assert property (p_wr_bad) else $error("unmapped write not refused");
	property p_rd_bad;
		arvalid && arready && araddr >= 12'h220 |=> rresp == 2'h2 && rdata == 32'h0;
	endproperty
	a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
	property p_aw_low;
		s_aw |=> (!awready) [*2];
	endproperty
	a_aw_low: assert property (p_aw_low) else $error("awready back too soon");
	// eight quiet cycles on the output
	sequence s_low8;
		(!serial_out_pin) [*8];
	endsequence
	// the zero byte stands well past 104 cycles after the frame opens
	property p_head_zero;
		$fell(chip_select_n) |-> ##1 s_low8 ##1 s_low8 ##1 s_low8 ##1 s_low8 ##1 s_low8 ##1 s_low8 ##1 s_low8
			##1 s_low8 ##1 s_low8 ##1 s_low8 ##1 s_low8 ##1 s_low8 ##1 s_low8;
	endproperty
	a_head_zero: assert property (p_head_zero) else $error("first out bits not zero");
	property p_en_on;
		$fell(chip_select_n) |-> ##[1:5] serial_out_en;
	endproperty
	a_en_on: assert property (p_en_on) else $error("output not enabled in frame");
	property p_idle;
		chip_select_n [*6] |-> !serial_out_en && !serial_out_pin;
	endproperty
	a_idle: assert property (p_idle) else $error("output active outside frame");
endmodule
bind host_serial_register_port port_checker chk (.aclk, .aresetn, .awvalid, .awready, .awaddr,
	.wvalid, .wready, .bvalid, .bresp, .arvalid, .arready, .araddr, .rvalid, .rdata, .rresp,
	.chip_select_n, .serial_out_pin, .serial_out_en);

// [tb/serial_host.sv]
// host side serial master model
`timescale 1ns/10ps
module serial_host (
	input wire aclk, // bench clock
	output logic serial_clk, // serial clock
	output logic chip_select_n, // frame, active low
	output logic serial_in_pin, // data to device
	input wire serial_out_pin, // data from device
	output logic done, // pulse per frame
	output logic [31:0] got // last bits seen
);
	initial
	begin
		serial_clk = 0;
		chip_select_n = 1;
		serial_in_pin = 0;
		done = 0;
		got = 0;
	end
	task automatic xfer(input int n, input logic [39:0] d);
		got = 0;
		chip_select_n = 0;
		#37;
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_clk = 1;
			serial_in_pin = d[i];
			#32;
			serial_clk = 0;
			got = {got[30:0], serial_out_pin};
			#32;
		end
		#20;
		chip_select_n = 1;
		serial_in_pin = ~serial_in_pin;
		#100;
		@(posedge aclk);
		done <= 1;
		@(posedge aclk);
		done <= 0;
	endtask
endmodule

// [tb/host_serial_register_port_test.sv]
// self-checking bench for the serial register port
`timescale 1ns/10ps
`include "serial_port_defines.vh"
module host_serial_register_port_test;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, probe = 0;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, got, r, q, seed = 32'h0FF7689A;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	logic [7:0] legal = `LEGAL_MODES, prev = 0;
	wire awready, wready, bvalid, arready, rvalid, serial_clk, chip_select_n, serial_in_pin, serial_out_pin;
	wire serial_out_en, irq, done;
	logic [63:0] exp_q[$];
	int failures = 0, check_count = 0;
	host_serial_register_port uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
		.wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.serial_clk, .chip_select_n, .serial_in_pin, .serial_out_pin, .serial_out_en, .irq);
	serial_host host (.aclk, .serial_clk, .chip_select_n, .serial_in_pin, .serial_out_pin, .done, .got);
	initial forever #2.5 aclk = ~aclk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic print_verdict();
		if (failures == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [63:0] e);
		check_count++;
		if ((seen & e[63:32]) !== e[31:0])
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, e[31:0]);
		end
	endtask
	task automatic note(input logic [31:0] m, v);
		exp_q.push_back({m, v});
	endtask
	// master holds each channel until its own handshake edge
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, m, v);
		int i;
		note(m, v);
		awaddr <= a;
		araddr <= a;
		wdata <= d;
		awvalid <= w;
		wvalid <= w;
		bready <= w;
		arvalid <= !w;
		rready <= !w;
		i = 0;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 0;
			if (wready)
				wvalid <= 0;
			if (bvalid)
				bready <= 0;
			if (arready)
				arvalid <= 0;
			if (rvalid)
				rready <= 0;
			i++;
		end
		while (i < 99 && (awvalid | wvalid | bready | arvalid | rready));
		if (i == 99)
		begin
			failures++;
			print_verdict();
		end
		// let an edge pass so the next call never re-drives a signal just lowered
		@(posedge aclk);
	endtask
	task automatic ser(input int n, input logic [39:0] d, input logic [31:0] m, v);
		note(m, v);
		host.xfer(n, d);
	endtask
	task automatic irqis(input logic e);
		note(1, e);
		probe <= 1;
		@(posedge aclk);
		probe <= 0;
	endtask
	always @(posedge aclk)
	begin
		if (rvalid && rready)
			check(rdata, exp_q.pop_front());
		if (bvalid && bready)
			check({30'h0, bresp}, exp_q.pop_front());
		if (done)
			check(got, exp_q.pop_front());
		if (probe)
			check({31'h0, irq}, exp_q.pop_front());
	end
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		bus(0, 12'h200, 0, '1, 0);
		bus(0, 12'h208, 0, '1, 0);
		bus(0, 12'h01C, 0, '1, 0);
		bus(0, 12'h300, 0, '1, 0);
		bus(1, 12'h300, 0, 3, 2);
		bus(1, 12'h200, 1, 3, 0);
		bus(1, 12'h208, 1, 3, 0);
		bus(1, 12'h214, 1, 3, 0);
		r = rnd();
		q = rnd();
		ser(16, {8'h0A, 8'hAB}, '1, 0);
		bus(0, 12'h014, 0, '1, 8'hAB);
		ser(32, {8'h0C, r[23:0]}, '1, 0);
		ser(32, {8'h0B, q[23:0]}, '1, {8'h00, 8'hAB, r[23:8]});
		bus(0, 12'h01C, 0, '1, r[15:8]);
		ser(40, {8'h0B, q}, '1, {8'hAB, r[23:8], q[8:1]});
		irqis(1);
		bus(0, 12'h204, 0, 1, 1);
		irqis(0);
		bus(1, 12'h208, 0, 3, 0);
		ser(17, {8'h0A, 9'h1FF}, 32'h1FE00, 0);
		irqis(0);
		bus(0, 12'h014, 0, '1, 8'hAB);
		bus(0, 12'h204, 0, 1, 1);
		ser(16, {8'h40, 8'h55}, 32'hFF00, 0);
		bus(0, 12'h080, 0, '1, 0);
		bus(0, 12'h204, 0, 1, 1);
		for (int c = 0; c < 8; c++)
		begin
			if (legal[c])
				prev = 8'(c);
			ser(16, {8'h02, 8'(c)}, 32'hFF00, 0);
			bus(0, 12'h004, 0, '1, prev);
			bus(0, 12'h204, 0, 1, !legal[c]);
		end
		ser(32, {8'hFC, r[23:0]}, '1, 0);
		bus(0, 12'h1FC, 0, '1, r[15:8]);
		bus(0, 12'h204, 0, 1, 0);
		print_verdict();
	end
endmodule
